// ==== hdl/sag_pkg.sv ====
// Shared definitions for the register access guard: modes, groups, offsets,
// reset values and the carriers that tie the guard to the core and to the table.
// Assumes a single 125 MHz core clock and an asynchronous active-high reset.
package sag_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths and table size
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SEG_COUNT   = 64;
  localparam int unsigned SEG_IDX_W   = 6;
  localparam int unsigned VADDR_W     = 16;

  //////////////////////////////////////////////////////////////////////////////
  // CPU modes and register groups
  typedef enum logic [2:0] {
    SAG_MODE_BOOT,
    SAG_MODE_TEST,
    SAG_MODE_CONTACTLESS,
    SAG_MODE_SYSTEM,
    SAG_MODE_USER
  } sag_mode_t;

  typedef enum logic [2:0] {
    SAG_GRP_GENERAL,
    SAG_GRP_SYSMGMT,
    SAG_GRP_SEGCFG,
    SAG_GRP_HWCOMP,
    SAG_GRP_NONE
  } sag_group_t;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_SCRATCH      = 8'h00;
  localparam logic [7:0] OFS_DENY_COUNT   = 8'h01;
  localparam logic [7:0] OFS_DENY_ADDR    = 8'h02;
  localparam logic [7:0] OFS_MODE_VIEW    = 8'h03;
  localparam logic [7:0] OFS_STATUS_UPPER = 8'h10;
  localparam logic [7:0] OFS_PAGE_PTR_A   = 8'h11;
  localparam logic [7:0] OFS_PAGE_PTR_B   = 8'h12;
  localparam logic [7:0] OFS_PAGE_PTR_C   = 8'h13;
  localparam logic [7:0] OFS_PARTITION    = 8'h14;
  localparam logic [7:0] OFS_SEG_BASE_LO  = 8'h20;
  localparam logic [7:0] OFS_SEG_BASE_HI  = 8'h21;
  localparam logic [7:0] OFS_HW_CTRL      = 8'h30;
  localparam logic [7:0] OFS_HW_DATA      = 8'h31;
  localparam logic [7:0] OFS_RANDOM       = 8'h32;

  // Group windows: upper nibble of the offset
  localparam logic [3:0] GRP_NIB_GENERAL  = 4'h0;
  localparam logic [3:0] GRP_NIB_SYSMGMT  = 4'h1;
  localparam logic [3:0] GRP_NIB_SEGCFG   = 4'h2;
  localparam logic [3:0] GRP_NIB_HWCOMP   = 4'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_SCRATCH      = 8'h00;
  localparam logic [7:0] RST_STATUS_UPPER = 8'h00;
  localparam logic [7:0] RST_PAGE_PTR     = 8'h00;
  localparam logic [7:0] RST_SEG_BASE     = 8'h00;
  localparam logic [7:0] RST_HW_CTRL      = 8'h00;
  localparam logic [7:0] RST_HW_DATA      = 8'h00;
  localparam logic [7:0] RST_RANDOM       = 8'h01;
  localparam logic [7:0] RST_DENY_COUNT   = 8'h00;
  localparam logic [7:0] RST_DENY_ADDR    = 8'h00;
  localparam logic [7:0] READ_DENIED      = 8'h00;
  // Hard-wired memory split, never writable
  localparam logic [7:0] PARTITION_FIXED  = 8'h5a;
  localparam logic [7:0] RANDOM_TAPS      = 8'hb8;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sag_req_t;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               ex;
    logic [VADDR_W-1:0] first;
    logic [VADDR_W-1:0] last;
    logic [VADDR_W-1:0] reloc;
    logic               hw_rd;
    logic               hw_wr;
  } sag_seg_entry_t;

endpackage : sag_pkg

// ==== hdl/sag_seg_table.sv ====
// Segment rights table: 64 entries in ordinary memory, one lookup port that
// follows the segment the current instruction came from.
// Assumes the table write port is driven by plain memory traffic, unguarded.
`timescale 1ns/100ps
`default_nettype none

module sag_seg_table (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      tbl_wr_i,
  input  wire logic [5:0]                tbl_idx_i,
  input  wire sag_pkg::sag_seg_entry_t   tbl_entry_i,
  input  wire logic [5:0]                fetch_seg_i,
  output var  sag_pkg::sag_seg_entry_t   fetch_entry_o,
  output logic                           fetch_valid_o
);

  sag_pkg::sag_seg_entry_t entry_mem [sag_pkg::SEG_COUNT];
  logic [sag_pkg::SEG_COUNT-1:0] written_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Storage; no guard on table writes at all
  always_ff @(posedge clk_i) begin
    if (tbl_wr_i) begin
      entry_mem[tbl_idx_i] <= tbl_entry_i;
    end
  end

  // Unwritten entries count as empty after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      written_reg <= '0;
    end else if (tbl_wr_i) begin
      written_reg[tbl_idx_i] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lookup; a segment with no rights at all is disabled
  wire entry_known = written_reg[fetch_seg_i];
  assign fetch_entry_o = entry_known ? entry_mem[fetch_seg_i] : '0;
  assign fetch_valid_o = entry_known &
                         (fetch_entry_o.rd | fetch_entry_o.wr | fetch_entry_o.ex |
                          fetch_entry_o.hw_rd | fetch_entry_o.hw_wr);

endmodule : sag_seg_table

`default_nettype wire

// ==== hdl/sag_guard.sv ====
// Register access guard: grants or refuses each register access of the core
// from the CPU mode and, in user mode, from the fetch segment's rights.
// Assumes mode and fetch segment come from core logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Boot mode may access every register group.
// - Test mode may access every register group, as boot mode.
// - Contactless mode reaches hardware registers, not segment registers; of the system group only the upper status word.
// - System mode reaches segment, system-management and hardware registers.
// - User mode reaches hardware registers per its fetch segment's rights.
// - General CPU registers are open in every mode.
// - Upper status word is readable, not writable, in contactless and user mode.
// - Segment configuration registers are refused in contactless and user mode.
// - The three page pointer registers never read back their content.
// - The random value register is read-only; writes do nothing.
// - Segment table address registers reset to zero.
// - The memory partition is fixed; no write changes it.
// - The segment table is plain memory with no extra guard.
// - Refused reads return zero; refused writes are dropped.
// - The segment table holds 64 entries with rights, bounds and offset.
module sag_guard (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire sag_pkg::sag_mode_t        mode_i,
  input  wire logic [5:0]                fetch_seg_i,
  input  wire sag_pkg::sag_req_t         req_i,
  input  wire logic                      tbl_wr_i,
  input  wire logic [5:0]                tbl_idx_i,
  input  wire sag_pkg::sag_seg_entry_t   tbl_entry_i,
  output logic [7:0]                     rd_data_o,
  output logic                           denied_o,
  output logic [15:0]                    seg_base_o,
  output logic [7:0]                     status_word_upper_o,
  output logic [7:0]                     page_ptr_a_o,
  output logic [7:0]                     page_ptr_b_o,
  output logic [7:0]                     page_ptr_c_o,
  output logic [7:0]                     hw_ctrl_o,
  output logic [7:0]                     hw_data_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  // Which group an offset belongs to
  function automatic sag_pkg::sag_group_t group_of(input logic [7:0] addr);
    sag_pkg::sag_group_t grp;
    grp = sag_pkg::SAG_GRP_NONE;
    if (addr[7:4] == sag_pkg::GRP_NIB_GENERAL) begin
      grp = sag_pkg::SAG_GRP_GENERAL;
    end else if (addr[7:4] == sag_pkg::GRP_NIB_SYSMGMT) begin
      grp = sag_pkg::SAG_GRP_SYSMGMT;
    end else if (addr[7:4] == sag_pkg::GRP_NIB_SEGCFG) begin
      grp = sag_pkg::SAG_GRP_SEGCFG;
    end else if (addr[7:4] == sag_pkg::GRP_NIB_HWCOMP) begin
      grp = sag_pkg::SAG_GRP_HWCOMP;
    end
    return grp;
  endfunction : group_of

  // Mode/group policy for one access direction
  function automatic logic grant_of(input sag_pkg::sag_mode_t  mode,
                                    input sag_pkg::sag_group_t grp,
                                    input logic [7:0]          addr,
                                    input logic                is_wr,
                                    input logic                seg_ok,
                                    input logic                seg_hw_rd,
                                    input logic                seg_hw_wr);
    logic ok;
    ok = 1'b0;
    case (grp)
      sag_pkg::SAG_GRP_GENERAL: begin
        ok = 1'b1;
      end
      sag_pkg::SAG_GRP_SEGCFG: begin
        ok = (mode == sag_pkg::SAG_MODE_BOOT) ||
             (mode == sag_pkg::SAG_MODE_TEST) ||
             (mode == sag_pkg::SAG_MODE_SYSTEM);
        // Boot and test are the configuration modes; all other non-system
        // modes are refused here.
      end
      sag_pkg::SAG_GRP_SYSMGMT: begin
        case (mode)
          sag_pkg::SAG_MODE_BOOT,
          sag_pkg::SAG_MODE_TEST,
          sag_pkg::SAG_MODE_SYSTEM: begin
            ok = 1'b1;
          end
          sag_pkg::SAG_MODE_CONTACTLESS,
          sag_pkg::SAG_MODE_USER: begin
            ok = !is_wr && (addr == sag_pkg::OFS_STATUS_UPPER);
          end
          default: begin
            ok = 1'b0;
          end
        endcase
      end
      sag_pkg::SAG_GRP_HWCOMP: begin
        case (mode)
          sag_pkg::SAG_MODE_BOOT,
          sag_pkg::SAG_MODE_TEST,
          sag_pkg::SAG_MODE_CONTACTLESS,
          sag_pkg::SAG_MODE_SYSTEM: begin
            ok = 1'b1;
          end
          sag_pkg::SAG_MODE_USER: begin
            ok = seg_ok && (is_wr ? seg_hw_wr : seg_hw_rd);
          end
          default: begin
            ok = 1'b0;
          end
        endcase
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : grant_of

  //////////////////////////////////////////////////////////////////////////////
  // Segment rights lookup

  sag_pkg::sag_seg_entry_t fetch_entry;
  logic                    fetch_valid;

  sag_seg_table u_table (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .tbl_wr_i      (tbl_wr_i),
    .tbl_idx_i     (tbl_idx_i),
    .tbl_entry_i   (tbl_entry_i),
    .fetch_seg_i   (fetch_seg_i),
    .fetch_entry_o (fetch_entry),
    .fetch_valid_o (fetch_valid)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0] scratch_reg;
  logic [7:0] status_word_upper_reg;
  logic [7:0] page_pointer_reg_a;
  logic [7:0] page_pointer_reg_b;
  logic [7:0] page_pointer_reg_c;
  logic [7:0] seg_base_lo_reg;
  logic [7:0] seg_base_hi_reg;
  logic [7:0] hw_ctrl_reg;
  logic [7:0] hw_data_reg;
  logic [7:0] random_value_reg;
  logic [7:0] deny_count_reg;
  logic [7:0] deny_addr_reg;
  logic [7:0] rd_data_reg;
  logic       denied_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Decision, same cycle as the access

  wire sag_pkg::sag_group_t acc_group = group_of(req_i.addr);
  wire acc_any   = req_i.wr | req_i.rd;
  wire acc_grant = grant_of(mode_i, acc_group, req_i.addr, req_i.wr,
                            fetch_valid, fetch_entry.hw_rd,
                            fetch_entry.hw_wr);
  wire wr_ok     = req_i.wr & acc_grant;
  wire rd_ok     = req_i.rd & acc_grant;
  wire deny_now  = acc_any & ~acc_grant;

  // Write enables per register, only behind a grant
  wire we_scratch   = wr_ok && (req_i.addr == sag_pkg::OFS_SCRATCH);
  wire we_status    = wr_ok && (req_i.addr == sag_pkg::OFS_STATUS_UPPER);
  wire we_page_a    = wr_ok && (req_i.addr == sag_pkg::OFS_PAGE_PTR_A);
  wire we_page_b    = wr_ok && (req_i.addr == sag_pkg::OFS_PAGE_PTR_B);
  wire we_page_c    = wr_ok && (req_i.addr == sag_pkg::OFS_PAGE_PTR_C);
  wire we_base_lo   = wr_ok && (req_i.addr == sag_pkg::OFS_SEG_BASE_LO);
  wire we_base_hi   = wr_ok && (req_i.addr == sag_pkg::OFS_SEG_BASE_HI);
  wire we_hw_ctrl   = wr_ok && (req_i.addr == sag_pkg::OFS_HW_CTRL);
  wire we_hw_data   = wr_ok && (req_i.addr == sag_pkg::OFS_HW_DATA);
  // Partition, random value and the read-only status views have no write
  // enable at all, so no mode can alter them

  // Read mux
  logic [7:0] rd_mux;
  assign rd_mux =
    (req_i.addr == sag_pkg::OFS_SCRATCH)      ? scratch_reg :
    (req_i.addr == sag_pkg::OFS_DENY_COUNT)   ? deny_count_reg :
    (req_i.addr == sag_pkg::OFS_DENY_ADDR)    ? deny_addr_reg :
    (req_i.addr == sag_pkg::OFS_MODE_VIEW)    ? {5'h00, mode_i} :
    (req_i.addr == sag_pkg::OFS_STATUS_UPPER) ? status_word_upper_reg :
    (req_i.addr == sag_pkg::OFS_PARTITION)    ? sag_pkg::PARTITION_FIXED :
    (req_i.addr == sag_pkg::OFS_SEG_BASE_LO)  ? seg_base_lo_reg :
    (req_i.addr == sag_pkg::OFS_SEG_BASE_HI)  ? seg_base_hi_reg :
    (req_i.addr == sag_pkg::OFS_HW_CTRL)      ? hw_ctrl_reg :
    (req_i.addr == sag_pkg::OFS_HW_DATA)      ? hw_data_reg :
    (req_i.addr == sag_pkg::OFS_RANDOM)       ? random_value_reg :
    sag_pkg::READ_DENIED;                 // page pointers and holes read zero

  wire [7:0] rd_data_next = rd_ok ? rd_mux : sag_pkg::READ_DENIED;

  // Random source runs freely
  wire [7:0] random_next = random_value_reg[0] ?
                           ((random_value_reg >> 1) ^ sag_pkg::RANDOM_TAPS) :
                           (random_value_reg >> 1);

  wire [7:0] deny_count_next = (deny_count_reg == 8'hff) ? deny_count_reg :
                               deny_count_reg + 8'h01;

  //////////////////////////////////////////////////////////////////////////////
  // General group

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scratch_reg <= sag_pkg::RST_SCRATCH;
    end else if (we_scratch) begin
      scratch_reg <= req_i.wdata;
    end
  end

  // Refusal log: saturating count and last refused offset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      deny_count_reg <= sag_pkg::RST_DENY_COUNT;
      deny_addr_reg  <= sag_pkg::RST_DENY_ADDR;
    end else if (deny_now) begin
      deny_count_reg <= deny_count_next;
      deny_addr_reg  <= req_i.addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System management group

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_word_upper_reg <= sag_pkg::RST_STATUS_UPPER;
    end else if (we_status) begin
      status_word_upper_reg <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_pointer_reg_a <= sag_pkg::RST_PAGE_PTR;
      page_pointer_reg_b <= sag_pkg::RST_PAGE_PTR;
      page_pointer_reg_c <= sag_pkg::RST_PAGE_PTR;
    end else begin
      if (we_page_a) begin
        page_pointer_reg_a <= req_i.wdata;
      end
      if (we_page_b) begin
        page_pointer_reg_b <= req_i.wdata;
      end
      if (we_page_c) begin
        page_pointer_reg_c <= req_i.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Segment configuration group

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seg_base_lo_reg <= sag_pkg::RST_SEG_BASE;
      seg_base_hi_reg <= sag_pkg::RST_SEG_BASE;
    end else begin
      if (we_base_lo) begin
        seg_base_lo_reg <= req_i.wdata;
      end
      if (we_base_hi) begin
        seg_base_hi_reg <= req_i.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware component group

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_ctrl_reg <= sag_pkg::RST_HW_CTRL;
      hw_data_reg <= sag_pkg::RST_HW_DATA;
    end else begin
      if (we_hw_ctrl) begin
        hw_ctrl_reg <= req_i.wdata;
      end
      if (we_hw_data) begin
        hw_data_reg <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      random_value_reg <= sag_pkg::RST_RANDOM;
    end else begin
      random_value_reg <= random_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg <= sag_pkg::READ_DENIED;
      denied_reg  <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      denied_reg  <= deny_now;
    end
  end

  assign rd_data_o           = rd_data_reg;
  assign denied_o            = denied_reg;
  assign seg_base_o          = {seg_base_hi_reg, seg_base_lo_reg};
  assign status_word_upper_o = status_word_upper_reg;
  assign page_ptr_a_o        = page_pointer_reg_a;
  assign page_ptr_b_o        = page_pointer_reg_b;
  assign page_ptr_c_o        = page_pointer_reg_c;
  assign hw_ctrl_o           = hw_ctrl_reg;
  assign hw_data_o           = hw_data_reg;

endmodule : sag_guard

`default_nettype wire

// ==== test/sag_guard_chk.sv ====
// Concurrent checks on the ports of the register access guard.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module sag_guard_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire sag_pkg::sag_mode_t      mode_i,
  input wire logic [5:0]              fetch_seg_i,
  input wire sag_pkg::sag_req_t       req_i,
  input wire logic                    tbl_wr_i,
  input wire logic [5:0]              tbl_idx_i,
  input wire sag_pkg::sag_seg_entry_t tbl_entry_i,
  input wire logic [7:0]              rd_data_o,
  input wire logic                    denied_o,
  input wire logic [15:0]             seg_base_o,
  input wire logic [7:0]              status_word_upper_o,
  input wire logic [7:0]              page_ptr_a_o,
  input wire logic [7:0]              page_ptr_b_o,
  input wire logic [7:0]              page_ptr_c_o,
  input wire logic [7:0]              hw_ctrl_o,
  input wire logic [7:0]              hw_data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  wire       acc = req_i.rd | req_i.wr;
  wire       bt  = (mode_i == sag_pkg::SAG_MODE_BOOT) | (mode_i == sag_pkg::SAG_MODE_TEST);
  wire       cu  = (mode_i == sag_pkg::SAG_MODE_CONTACTLESS) | (mode_i == sag_pkg::SAG_MODE_USER);
  wire       sys = (mode_i == sag_pkg::SAG_MODE_SYSTEM);
  wire [7:0] a   = req_i.addr;

  //////////////////////////////////////////////////////////////////////////////
  property p_idle; !acc |=> !denied_o && rd_data_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_gen; acc && a[7:4] == 4'h0 |=> !denied_o;
  endproperty
  a_gen: assert property (p_gen) else $error("general register refused");
  property p_all; acc && bt && a < 8'h40 |=> !denied_o;
  endproperty
  a_all: assert property (p_all) else $error("boot or test access refused");
  property p_seg; req_i.wr && a[7:4] == 4'h2 && cu |=> denied_o && $stable(seg_base_o);
  endproperty
  a_seg: assert property (p_seg) else $error("segment base written");
  property p_sys; req_i.wr && sys && a == 8'h20 |=> seg_base_o[7:0] == $past(req_i.wdata);
  endproperty
  a_sys: assert property (p_sys) else $error("system write lost");
  property p_pswr; req_i.rd && cu && a == 8'h10 |=> !denied_o && rd_data_o == status_word_upper_o;
  endproperty
  a_pswr: assert property (p_pswr) else $error("status read refused");
  property p_psww; req_i.wr && cu && a == 8'h10 |=> denied_o && $stable(status_word_upper_o);
  endproperty
  a_psww: assert property (p_psww) else $error("status written");
  property p_page; req_i.rd && a inside {8'h11, 8'h12, 8'h13} |=> rd_data_o == 8'h00;
  endproperty
  a_page: assert property (p_page) else $error("page pointer read back");
  property p_den; req_i.rd ##1 denied_o |-> rd_data_o == 8'h00;
  endproperty
  a_den: assert property (p_den) else $error("refused read not zero");
  property p_hw; req_i.wr && mode_i == sag_pkg::SAG_MODE_CONTACTLESS && a == 8'h30
    |=> !denied_o && hw_ctrl_o == $past(req_i.wdata);
  endproperty
  a_hw: assert property (p_hw) else $error("hardware write lost");
  property p_part; req_i.rd && sys && a == 8'h14 |=> rd_data_o == sag_pkg::PARTITION_FIXED;
  endproperty
  a_part: assert property (p_part) else $error("partition changed");
  property p_rst; $past(rst_i) |-> seg_base_o == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("segment base not cleared");
endmodule : sag_guard_chk

bind sag_guard sag_guard_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
  .fetch_seg_i(fetch_seg_i), .req_i(req_i), .tbl_wr_i(tbl_wr_i), .tbl_idx_i(tbl_idx_i),
  .tbl_entry_i(tbl_entry_i), .rd_data_o(rd_data_o), .denied_o(denied_o),
  .seg_base_o(seg_base_o), .status_word_upper_o(status_word_upper_o),
  .page_ptr_a_o(page_ptr_a_o), .page_ptr_b_o(page_ptr_b_o), .page_ptr_c_o(page_ptr_c_o),
  .hw_ctrl_o(hw_ctrl_o), .hw_data_o(hw_data_o));
`default_nettype wire

// ==== test/sag_cpu_model.sv ====
// Core model: issues register accesses and writes segment table entries.
// Assumes the guard answers one cycle after each request edge.
`timescale 1ns/100ps
`default_nettype none

module sag_cpu_model (
  input  wire logic                    clk_i,
  input  wire logic [7:0]              rd_data_i,
  input  wire logic                    denied_i,
  output var  sag_pkg::sag_mode_t      mode_o,
  output logic [5:0]                   fetch_seg_o,
  output var  sag_pkg::sag_req_t       req_o,
  output logic                         tbl_wr_o,
  output logic [5:0]                   tbl_idx_o,
  output var  sag_pkg::sag_seg_entry_t tbl_entry_o
);
  initial begin
    mode_o      = sag_pkg::SAG_MODE_BOOT;
    fetch_seg_o = 6'h00;
    req_o       = '0;
    tbl_wr_o    = 1'b0;
    tbl_idx_o   = 6'h00;
    tbl_entry_o = '0;
  end

  // One-cycle request; the answer is taken in the cycle after
  task automatic acc(input sag_pkg::sag_mode_t m, input logic [5:0] sg, input logic wr,
                     input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic den);
    @(posedge clk_i);
    mode_o      <= m;
    fetch_seg_o <= sg;
    req_o       <= '{addr: a, wdata: d, wr: wr, rd: !wr};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    q   = rd_data_i;
    den = denied_i;
  endtask : acc

  task automatic tbl(input logic [5:0] idx, input logic hr, input logic hw);
    @(posedge clk_i);
    tbl_wr_o    <= 1'b1;
    tbl_idx_o   <= idx;
    tbl_entry_o <= '{rd: 1'b1, wr: 1'b0, ex: 1'b1, first: 16'h0000, last: 16'hffff,
                     reloc: 16'h0000, hw_rd: hr, hw_wr: hw};
    @(posedge clk_i);
    tbl_wr_o <= 1'b0;
  endtask : tbl
endmodule : sag_cpu_model
`default_nettype wire

// ==== test/sag_guard_tb.sv ====
// Testbench for the register access guard: mode and segment sequences.
// Assumes the core model in sag_cpu_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module sag_guard_tb;
  localparam sag_pkg::sag_mode_t m_boot = sag_pkg::SAG_MODE_BOOT;
  localparam sag_pkg::sag_mode_t m_test = sag_pkg::SAG_MODE_TEST;
  localparam sag_pkg::sag_mode_t m_cl   = sag_pkg::SAG_MODE_CONTACTLESS;
  localparam sag_pkg::sag_mode_t m_sys  = sag_pkg::SAG_MODE_SYSTEM;
  localparam sag_pkg::sag_mode_t m_usr  = sag_pkg::SAG_MODE_USER;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  int   bad_count = 0;
  int   n_checks = 0;
  int   cyc = 0;
  sag_pkg::sag_mode_t      mode;
  sag_pkg::sag_req_t       req;
  sag_pkg::sag_seg_entry_t tbl_entry;
  logic [5:0]  seg, tbl_idx;
  logic        tbl_wr, denied, den;
  logic [7:0]  rd_data, status_upper, ppa, ppb, ppc, hw_ctrl, hw_data, q;
  logic [15:0] seg_base;

  sag_guard dut_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .fetch_seg_i(seg),
    .req_i(req), .tbl_wr_i(tbl_wr), .tbl_idx_i(tbl_idx), .tbl_entry_i(tbl_entry),
    .rd_data_o(rd_data), .denied_o(denied), .seg_base_o(seg_base),
    .status_word_upper_o(status_upper), .page_ptr_a_o(ppa), .page_ptr_b_o(ppb),
    .page_ptr_c_o(ppc), .hw_ctrl_o(hw_ctrl), .hw_data_o(hw_data));
  sag_cpu_model cpu_u (.clk_i(clk_i), .rd_data_i(rd_data), .denied_i(denied),
    .mode_o(mode), .fetch_seg_o(seg), .req_o(req), .tbl_wr_o(tbl_wr),
    .tbl_idx_o(tbl_idx), .tbl_entry_o(tbl_entry));

  initial begin
    forever #4 clk_i = !clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Access, then compare read data (reads only) and the refusal flag
  task automatic ac(input sag_pkg::sag_mode_t m, input logic [5:0] sg, input logic wr,
                    input logic [7:0] a, input logic [7:0] d, input logic [7:0] eq,
                    input logic ed);
    cpu_u.acc(m, sg, wr, a, d, q, den);
    if (!wr) check("read data", {8'h00, eq}, {8'h00, q});
    check("refusal", {15'h0000, ed}, {15'h0000, den});
  endtask : ac

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    check("seg base", 16'h0000, seg_base);
    ac(m_boot, 6'd0, 1'b1, 8'h30, 8'ha5, 8'h00, 1'b0);
    ac(m_boot, 6'd0, 1'b0, 8'h30, 8'h00, 8'ha5, 1'b0);
    ac(m_boot, 6'd0, 1'b1, 8'h20, 8'h34, 8'h00, 1'b0);
    ac(m_boot, 6'd0, 1'b0, 8'h40, 8'h00, 8'h00, 1'b1);
    ac(m_test, 6'd0, 1'b1, 8'h21, 8'h12, 8'h00, 1'b0);
    ac(m_test, 6'd0, 1'b0, 8'h21, 8'h00, 8'h12, 1'b0);
    check("seg base", 16'h1234, seg_base);
    ac(m_cl, 6'd0, 1'b1, 8'h30, 8'h3c, 8'h00, 1'b0);
    check("hw ctrl", 16'h003c, {8'h00, hw_ctrl});
    ac(m_cl, 6'd0, 1'b1, 8'h20, 8'hff, 8'h00, 1'b1);
    ac(m_cl, 6'd0, 1'b0, 8'h21, 8'h00, 8'h00, 1'b1);
    check("seg base", 16'h1234, seg_base);
    ac(m_cl, 6'd0, 1'b1, 8'h10, 8'h77, 8'h00, 1'b1);
    ac(m_cl, 6'd0, 1'b0, 8'h10, 8'h00, 8'h00, 1'b0);
    ac(m_cl, 6'd0, 1'b0, 8'h11, 8'h00, 8'h00, 1'b1);
    ac(m_sys, 6'd0, 1'b1, 8'h10, 8'h66, 8'h00, 1'b0);
    ac(m_sys, 6'd0, 1'b1, 8'h11, 8'h99, 8'h00, 1'b0);
    check("page ptr", 16'h0099, {8'h00, ppa});
    ac(m_sys, 6'd0, 1'b0, 8'h11, 8'h00, 8'h00, 1'b0);
    ac(m_sys, 6'd0, 1'b1, 8'h20, 8'h56, 8'h00, 1'b0);
    check("seg base", 16'h1256, seg_base);
    ac(m_sys, 6'd0, 1'b1, 8'h14, 8'h00, 8'h00, 1'b0);
    ac(m_sys, 6'd0, 1'b0, 8'h14, 8'h00, 8'h5a, 1'b0);
    ac(m_sys, 6'd0, 1'b1, 8'h32, 8'h00, 8'h00, 1'b0);
    cpu_u.acc(m_sys, 6'd0, 1'b0, 8'h32, 8'h00, q, den);
    check("random live", 16'h0001, {15'h0000, q != 8'h00});
    ac(m_sys, 6'd0, 1'b1, 8'h12, 8'ha1, 8'h00, 1'b0);
    ac(m_sys, 6'd0, 1'b1, 8'h13, 8'hb2, 8'h00, 1'b0);
    check("page ptr bc", 16'ha1b2, {ppb, ppc});
    ac(m_sys, 6'd0, 1'b1, 8'h31, 8'h5e, 8'h00, 1'b0);
    check("hw data", 16'h005e, {8'h00, hw_data});
    ac(m_sys, 6'd0, 1'b0, 8'h01, 8'h00, 8'h05, 1'b0);
    ac(m_sys, 6'd0, 1'b0, 8'h02, 8'h00, 8'h11, 1'b0);
    ac(m_sys, 6'd0, 1'b0, 8'h03, 8'h00, 8'h03, 1'b0);
    ac(m_usr, 6'd5, 1'b1, 8'h00, 8'h42, 8'h00, 1'b0);
    ac(m_usr, 6'd5, 1'b0, 8'h00, 8'h00, 8'h42, 1'b0);
    ac(m_usr, 6'd5, 1'b0, 8'h10, 8'h00, 8'h66, 1'b0);
    ac(m_usr, 6'd5, 1'b1, 8'h21, 8'h00, 8'h00, 1'b1);
    ac(m_usr, 6'd5, 1'b0, 8'h30, 8'h00, 8'h00, 1'b1);
    cpu_u.tbl(6'd5, 1'b1, 1'b0);
    ac(m_usr, 6'd5, 1'b0, 8'h30, 8'h00, 8'h3c, 1'b0);
    ac(m_usr, 6'd5, 1'b1, 8'h30, 8'h11, 8'h00, 1'b1);
    cpu_u.tbl(6'd63, 1'b0, 1'b1);
    ac(m_usr, 6'd63, 1'b1, 8'h30, 8'hc3, 8'h00, 1'b0);
    ac(m_usr, 6'd63, 1'b0, 8'h30, 8'h00, 8'h00, 1'b1);
    check("hw ctrl", 16'h00c3, {8'h00, hw_ctrl});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("seg base", 16'h0000, seg_base);
    check("status upper", 16'h0000, {8'h00, status_upper});
    ac(m_usr, 6'd5, 1'b0, 8'h30, 8'h00, 8'h00, 1'b1);
    wrap_up();
  end
endmodule : sag_guard_tb
`default_nettype wire
